// ### src/sfs_pkg.sv
// Constants shared by the status and configuration register block
package sfs_pkg;
    // Instruction codes
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RD_S1 = 8'h05;
    localparam logic [7:0] OP_RD_S2 = 8'h35;
    localparam logic [7:0] OP_RD_S3 = 8'h15;
    localparam logic [7:0] OP_WR_S1 = 8'h01;
    localparam logic [7:0] OP_WR_S2 = 8'h31;
    localparam logic [7:0] OP_WR_S3 = 8'h11;
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7a;
    localparam logic [7:0] OP_ENTER_4B = 8'hb7;
    localparam logic [7:0] OP_EXIT_4B = 8'he9;
    localparam logic [7:0] OP_PAGE_PROG = 8'h02;
    localparam logic [7:0] OP_QUAD_PROG = 8'h32;
    localparam logic [7:0] OP_SECT_ERASE = 8'h20;
    localparam logic [7:0] OP_BLK_ERASE = 8'hd8;
    localparam logic [7:0] OP_CHIP_ERASE = 8'hc7;
    localparam logic [7:0] OP_SEC_ERASE = 8'h44;
    localparam logic [7:0] OP_SEC_PROG = 8'h42;
    // Frame lengths and field capture positions in serial bits
    localparam logic [5:0] BITS_OPCODE = 6'h08;
    localparam logic [5:0] BITS_ONE_DATA = 6'h10;
    localparam logic [5:0] BITS_ADDR3 = 6'h20;
    localparam logic [5:0] BITS_ADDR4 = 6'h28;
    localparam logic [5:0] CAP_BYTE1 = 6'h0f;
    localparam logic [5:0] CAP_ADDR3 = 6'h1f;
    localparam logic [5:0] CAP_ADDR4 = 6'h27;
    // Field positions inside each status byte
    localparam int S1_BUSY = 0;
    localparam int S1_WEL = 1;
    localparam int S1_BP_LO = 2;
    localparam int S1_TB = 6;
    localparam int S1_SRP = 7;
    localparam int S2_SRL = 0;
    localparam int S2_QE = 1;
    localparam int S2_LB_LO = 2;
    localparam int S2_CMP = 6;
    localparam int S2_SUS = 7;
    localparam int S3_ADS = 0;
    localparam int S3_ADP = 1;
    localparam int S3_WPS = 2;
    localparam int S3_DRV_LO = 5;
    localparam int S3_DRV_HI = 6;
    // Values after power-up, and the protect level from which the whole array is covered
    localparam logic [3:0] BP_RESET = 4'h0;
    localparam logic [3:0] LB_RESET = 4'h0;
    localparam logic [1:0] DRV_RESET = 2'h0;
    localparam logic [3:0] BP_ALL_FROM = 4'hb;
    // Busy time of any program, erase or status write, in system cycles
    localparam logic [15:0] BUSY_CYCLES = 16'h0010;
    localparam int ADDR_W = 32;
endpackage

// ### src/sfs_pin_filter.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module sfs_pin_filter #(
    parameter logic RESET_VALUE = 1'b1
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic pin_in,
    output logic level_out
);
    logic stage1_reg;
    logic stage2_reg;
    logic stage3_reg;
    logic level_reg;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            stage1_reg <= RESET_VALUE;
            stage2_reg <= RESET_VALUE;
            stage3_reg <= RESET_VALUE;
        end else if (clk_en) begin
            stage1_reg <= pin_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // A change counts only once the two later stages agree
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            level_reg <= RESET_VALUE;
        end else if (clk_en && stage2_reg == stage3_reg) begin
            level_reg <= stage3_reg;
        end
    end

    assign level_out = level_reg;
endmodule
`default_nettype wire

// ### src/sfs_status_regs.sv
// Status and configuration registers of a serial flash, with serial front end
`timescale 1ns/1ps
`default_nettype none
module sfs_status_regs #(
    parameter logic [15:0] BUSY_TIME = sfs_pkg::BUSY_CYCLES
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso_o,
    output logic spi_miso_oe,
    input wire logic wp_n,
    output logic busy,
    output logic write_enable_latch,
    output logic suspend_flag,
    output logic quad_enable,
    output logic hold_enable,
    output logic current_addr_mode,
    output logic protect_scheme_select,
    output logic drive_strength_hi,
    output logic drive_strength_lo,
    output logic array_op_go,
    output logic [7:0] array_op_code,
    output logic [31:0] array_op_addr,
    output logic array_op_refused
);
    typedef enum logic [2:0] {
        SFS_IDLE = 3'b001,
        SFS_BUSY = 3'b010,
        SFS_SUSPENDED = 3'b100
    } sfs_state_t;

    // Link side, clocked by the serial clock
    logic [5:0] bit_cnt_reg;
    logic frame_start_reg;
    logic [5:0] link_cnt;
    logic [7:0] opc_sh_reg;
    logic [7:0] opc_reg;
    logic [31:0] data_sh_reg;
    logic [7:0] byte1_reg;
    logic [23:0] addr3_reg;
    logic [31:0] addr4_reg;
    logic miso_reg;
    logic miso_oe_reg;

    // System side
    sfs_state_t state_reg;
    logic [15:0] busy_cnt_reg;
    logic busy_op_array_reg;
    logic wel_reg;
    logic [3:0] bp_reg;
    logic tb_reg;
    logic srp_reg;
    logic srl_reg;
    logic qe_reg;
    logic [3:0] lb_reg;
    logic cmp_reg;
    logic sus_reg;
    logic ads_reg;
    // Kept across device reset, else the power-up mode could never be 1
    logic adp_reg = 1'b0;
    logic wps_reg;
    logic [1:0] drv_reg;
    logic locks_all_reg;
    logic init_pending_reg;
    logic cs_prev_reg;
    logic [23:0] pub_reg;
    logic hold_reg;
    logic go_reg;
    logic refused_reg;
    logic [7:0] go_code_reg;
    logic [31:0] go_addr_reg;
    logic cs_level;
    logic wp_level;
    logic frame_end;
    logic [23:0] status_now;
    logic status_write_ok;
    logic [31:0] target_addr;
    logic addr_ok;
    logic target_locked;

    sfs_pin_filter #(
        .RESET_VALUE(1'b1)
    ) u_cs_filter (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .pin_in(spi_cs_n),
        .level_out(cs_level)
    );

    sfs_pin_filter #(
        .RESET_VALUE(1'b1)
    ) u_wp_filter (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .pin_in(wp_n),
        .level_out(wp_level)
    );

    // Is a 64 KB block inside the range set by top/bottom, protect and complement
    function automatic logic range_hit(input logic tb, input logic [3:0] bp,
                                       input logic cmp, input logic [9:0] blk);
        logic [10:0] size;
        logic hit;
        size = 11'h001 << (bp - 4'h1);
        if (bp == 4'h0) begin
            hit = 1'b0;
        end else if (bp >= sfs_pkg::BP_ALL_FROM) begin
            hit = 1'b1;
        end else if (tb) begin
            hit = {1'b0, blk} < size;
        end else begin
            hit = {1'b0, blk} >= (11'h400 - size);
        end
        return hit ^ cmp;
    endfunction

    // Chip erase is refused if any part of the array is protected
    function automatic logic any_hit(input logic [3:0] bp, input logic cmp);
        return cmp ? (bp < sfs_pkg::BP_ALL_FROM) : (bp != 4'h0);
    endfunction

    // Frame start flag, raised while chip select is high
    always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            frame_start_reg <= 1'b1;
        end else begin
            frame_start_reg <= 1'b0;
        end
    end

    assign link_cnt = frame_start_reg ? 6'h00 : bit_cnt_reg;

    // Frame capture: count and shift state survive chip select rising and
    // stay steady while the system side reads them, so no word synchroniser
    always_ff @(posedge spi_sclk) begin
        if (link_cnt != 6'h3f) begin
            bit_cnt_reg <= link_cnt + 6'h01;
        end
        if (link_cnt < sfs_pkg::BITS_OPCODE) begin
            opc_sh_reg <= {opc_sh_reg[6:0], spi_mosi};
        end
    end

    always_ff @(posedge spi_sclk) begin
        if (link_cnt == sfs_pkg::BITS_OPCODE - 6'h01) begin
            opc_reg <= {opc_sh_reg[6:0], spi_mosi};
        end
        if (link_cnt >= sfs_pkg::BITS_OPCODE) begin
            data_sh_reg <= {data_sh_reg[30:0], spi_mosi};
        end
        if (link_cnt == sfs_pkg::CAP_BYTE1) begin
            byte1_reg <= {data_sh_reg[6:0], spi_mosi};
        end
        if (link_cnt == sfs_pkg::CAP_ADDR3) begin
            addr3_reg <= {data_sh_reg[22:0], spi_mosi};
        end
        if (link_cnt == sfs_pkg::CAP_ADDR4) begin
            addr4_reg <= {data_sh_reg[30:0], spi_mosi};
        end
    end

    // Read data leaves on the falling edge; the published copy only
    // changes between frames, so it is steady while it is shifted out
    always_ff @(negedge spi_sclk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            miso_reg <= 1'b0;
            miso_oe_reg <= 1'b0;
        end else if (bit_cnt_reg >= sfs_pkg::BITS_OPCODE) begin
            case (opc_reg)
                sfs_pkg::OP_RD_S1: begin
                    miso_oe_reg <= 1'b1;
                    miso_reg <= pub_reg[{2'b00, ~bit_cnt_reg[2:0]}];
                end
                sfs_pkg::OP_RD_S2: begin
                    miso_oe_reg <= 1'b1;
                    miso_reg <= pub_reg[{2'b01, ~bit_cnt_reg[2:0]}];
                end
                sfs_pkg::OP_RD_S3: begin
                    miso_oe_reg <= 1'b1;
                    miso_reg <= pub_reg[{2'b10, ~bit_cnt_reg[2:0]}];
                end
                default: begin
                    miso_oe_reg <= 1'b0;
                    miso_reg <= 1'b0;
                end
            endcase
        end
    end

    assign frame_end = cs_level && !cs_prev_reg;

    always_comb begin
        status_now = 24'h000000;
        status_now[sfs_pkg::S1_BUSY] = (state_reg == SFS_BUSY);
        status_now[sfs_pkg::S1_WEL] = wel_reg;
        status_now[sfs_pkg::S1_BP_LO +: 4] = bp_reg;
        status_now[sfs_pkg::S1_TB] = tb_reg;
        status_now[sfs_pkg::S1_SRP] = srp_reg;
        status_now[8 + sfs_pkg::S2_SRL] = srl_reg;
        status_now[8 + sfs_pkg::S2_QE] = qe_reg;
        status_now[8 + sfs_pkg::S2_LB_LO +: 4] = lb_reg;
        status_now[8 + sfs_pkg::S2_CMP] = cmp_reg;
        status_now[8 + sfs_pkg::S2_SUS] = sus_reg;
        status_now[16 + sfs_pkg::S3_ADS] = ads_reg;
        status_now[16 + sfs_pkg::S3_ADP] = adp_reg;
        status_now[16 + sfs_pkg::S3_WPS] = wps_reg;
        status_now[16 + sfs_pkg::S3_DRV_LO] = drv_reg[0];
        status_now[16 + sfs_pkg::S3_DRV_HI] = drv_reg[1];
    end

    // Pin is a data line in quad mode and then plays no part
    always_comb begin
        if (!wel_reg || srl_reg || bit_cnt_reg < sfs_pkg::BITS_ONE_DATA) begin
            status_write_ok = 1'b0;
        end else if (!srp_reg) begin
            status_write_ok = 1'b1;
        end else begin
            status_write_ok = qe_reg || wp_level;
        end
    end

    always_comb begin
        if (ads_reg) begin
            target_addr = addr4_reg;
            addr_ok = bit_cnt_reg >= sfs_pkg::BITS_ADDR4;
        end else begin
            target_addr = {8'h00, addr3_reg};
            addr_ok = bit_cnt_reg >= sfs_pkg::BITS_ADDR3;
        end
        if (wps_reg) begin
            target_locked = locks_all_reg;
        end else if (opc_reg == sfs_pkg::OP_CHIP_ERASE) begin
            target_locked = any_hit(bp_reg, cmp_reg);
        end else begin
            target_locked = range_hit(tb_reg, bp_reg, cmp_reg, target_addr[25:16]);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cs_prev_reg <= 1'b1;
            pub_reg <= 24'h000000;
            hold_reg <= 1'b1;
        end else if (clk_en) begin
            cs_prev_reg <= cs_level;
            if (cs_level) begin
                pub_reg <= status_now;
                hold_reg <= !status_now[8 + sfs_pkg::S2_QE];
            end
        end
    end

    // Instruction execution, sequencing and busy timing
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_reg <= SFS_IDLE;
            busy_cnt_reg <= 16'h0000;
            busy_op_array_reg <= 1'b0;
            wel_reg <= 1'b0;
            sus_reg <= 1'b0;
            go_reg <= 1'b0;
            refused_reg <= 1'b0;
            go_code_reg <= 8'h00;
            go_addr_reg <= 32'h00000000;
        end else if (clk_en) begin
            go_reg <= 1'b0;
            refused_reg <= 1'b0;
            if (state_reg == SFS_BUSY) begin
                if (busy_cnt_reg == 16'h0001) begin
                    state_reg <= SFS_IDLE;
                end
                busy_cnt_reg <= busy_cnt_reg - 16'h0001;
            end
            if (frame_end && bit_cnt_reg >= sfs_pkg::BITS_OPCODE) begin
                case (state_reg)
                    SFS_BUSY: begin
                        // Only reads (handled on the link) and suspend get through
                        if (opc_reg == sfs_pkg::OP_SUSPEND && busy_op_array_reg) begin
                            state_reg <= SFS_SUSPENDED;
                            sus_reg <= 1'b1;
                        end
                    end
                    SFS_IDLE, SFS_SUSPENDED: begin
                        case (opc_reg)
                            sfs_pkg::OP_WREN: wel_reg <= 1'b1;
                            sfs_pkg::OP_WRDI: wel_reg <= 1'b0;
                            sfs_pkg::OP_RESUME: begin
                                if (state_reg == SFS_SUSPENDED) begin
                                    state_reg <= SFS_BUSY;
                                    sus_reg <= 1'b0;
                                end
                            end
                            sfs_pkg::OP_WR_S1, sfs_pkg::OP_WR_S2, sfs_pkg::OP_WR_S3: begin
                                if (status_write_ok) begin
                                    wel_reg <= 1'b0;
                                    if (state_reg == SFS_IDLE) begin
                                        state_reg <= SFS_BUSY;
                                        busy_cnt_reg <= BUSY_TIME;
                                        busy_op_array_reg <= 1'b0;
                                    end
                                end
                            end
                            sfs_pkg::OP_PAGE_PROG, sfs_pkg::OP_QUAD_PROG,
                            sfs_pkg::OP_SECT_ERASE, sfs_pkg::OP_BLK_ERASE,
                            sfs_pkg::OP_CHIP_ERASE, sfs_pkg::OP_SEC_ERASE,
                            sfs_pkg::OP_SEC_PROG: begin
                                if (wel_reg && state_reg == SFS_IDLE
                                    && (addr_ok || opc_reg == sfs_pkg::OP_CHIP_ERASE)
                                    && (opc_reg != sfs_pkg::OP_QUAD_PROG || qe_reg)) begin
                                    wel_reg <= 1'b0;
                                    go_code_reg <= opc_reg;
                                    go_addr_reg <= target_addr;
                                    if ((opc_reg == sfs_pkg::OP_SEC_ERASE
                                         || opc_reg == sfs_pkg::OP_SEC_PROG)
                                        ? lb_reg[target_addr[13:12]]
                                        : target_locked) begin
                                        refused_reg <= 1'b1;
                                    end else begin
                                        go_reg <= 1'b1;
                                        state_reg <= SFS_BUSY;
                                        busy_cnt_reg <= BUSY_TIME;
                                        busy_op_array_reg <= 1'b1;
                                    end
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                    default: state_reg <= SFS_IDLE;
                endcase
            end
        end
    end

    // Status write contents; reserved positions are never stored
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            bp_reg <= sfs_pkg::BP_RESET;
            tb_reg <= 1'b0;
            srp_reg <= 1'b0;
            srl_reg <= 1'b0;
            qe_reg <= 1'b0;
            lb_reg <= sfs_pkg::LB_RESET;
            cmp_reg <= 1'b0;
            wps_reg <= 1'b0;
            drv_reg <= sfs_pkg::DRV_RESET;
        end else if (clk_en && frame_end && state_reg == SFS_IDLE && status_write_ok) begin
            case (opc_reg)
                sfs_pkg::OP_WR_S1: begin
                    bp_reg <= byte1_reg[sfs_pkg::S1_BP_LO +: 4];
                    tb_reg <= byte1_reg[sfs_pkg::S1_TB];
                    srp_reg <= byte1_reg[sfs_pkg::S1_SRP];
                end
                sfs_pkg::OP_WR_S2: begin
                    srl_reg <= byte1_reg[sfs_pkg::S2_SRL];
                    qe_reg <= byte1_reg[sfs_pkg::S2_QE];
                    lb_reg <= lb_reg | byte1_reg[sfs_pkg::S2_LB_LO +: 4];
                    cmp_reg <= byte1_reg[sfs_pkg::S2_CMP];
                end
                sfs_pkg::OP_WR_S3: begin
                    adp_reg <= byte1_reg[sfs_pkg::S3_ADP];
                    wps_reg <= byte1_reg[sfs_pkg::S3_WPS];
                    drv_reg <= {byte1_reg[sfs_pkg::S3_DRV_HI],
                                byte1_reg[sfs_pkg::S3_DRV_LO]};
                end
                default: begin
                end
            endcase
        end
    end

    // Address mode: power-up bit is taken one cycle after reset release
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            init_pending_reg <= 1'b1;
            ads_reg <= 1'b0;
            locks_all_reg <= 1'b1;
        end else if (clk_en) begin
            init_pending_reg <= 1'b0;
            if (init_pending_reg) begin
                ads_reg <= adp_reg;
            end else if (frame_end && state_reg != SFS_BUSY
                         && bit_cnt_reg >= sfs_pkg::BITS_OPCODE) begin
                if (opc_reg == sfs_pkg::OP_ENTER_4B) begin
                    ads_reg <= 1'b1;
                end else if (opc_reg == sfs_pkg::OP_EXIT_4B) begin
                    ads_reg <= 1'b0;
                end
            end
        end
    end

    assign spi_miso_o = miso_reg;
    assign spi_miso_oe = miso_oe_reg;
    assign busy = pub_reg[sfs_pkg::S1_BUSY];
    assign write_enable_latch = wel_reg;
    assign suspend_flag = sus_reg;
    assign quad_enable = qe_reg;
    assign hold_enable = hold_reg;
    assign current_addr_mode = ads_reg;
    assign protect_scheme_select = wps_reg;
    assign drive_strength_hi = drv_reg[1];
    assign drive_strength_lo = drv_reg[0];
    assign array_op_go = go_reg;
    assign array_op_code = go_code_reg;
    assign array_op_addr = go_addr_reg;
    assign array_op_refused = refused_reg;
endmodule
`default_nettype wire

// ### dv/sfs_status_regs_chk.sv
// Port assertions for the status register block
`timescale 1ns/1ps
`default_nettype none
module sfs_status_regs_chk #(
    parameter logic [15:0] BUSY_TIME = 16'h0010
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic busy,
    input wire logic write_enable_latch,
    input wire logic quad_enable,
    input wire logic hold_enable,
    input wire logic current_addr_mode,
    input wire logic protect_scheme_select,
    input wire logic array_op_go,
    input wire logic array_op_refused
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    logic [15:0] busy_cnt_reg;
    // Counter, since a repetition cannot span the busy time
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !busy) begin
            busy_cnt_reg <= 16'h0000;
        end else begin
            busy_cnt_reg <= busy_cnt_reg + 16'h0001;
        end
    end
    chk_busy_ends: assert property (busy_cnt_reg <= BUSY_TIME + 16'h0002)
        else $error("busy held too long");
    chk_op_pulse: assert property (array_op_go || array_op_refused |=> !array_op_go)
        else $error("array op pulse too long");
    chk_op_excl: assert property (!(array_op_go && array_op_refused))
        else $error("array op both taken and refused");
    chk_go_busy: assert property (array_op_go |-> ##[0:2] busy)
        else $error("busy missing after array op");
    chk_op_wel: assert property (array_op_go || array_op_refused |-> ##[0:2] !write_enable_latch)
        else $error("write latch kept after array op");
    chk_wel_idle: assert property ($rose(write_enable_latch) |-> !$past(busy))
        else $error("write latch set while busy");
    chk_hold_quad: assert property ($stable(quad_enable) [*3] |-> hold_enable != quad_enable)
        else $error("hold not inverse of quad");
    chk_busy_frozen: assert property (busy && $past(busy) |->
        $stable(current_addr_mode) && $stable(protect_scheme_select))
        else $error("config changed while busy");
endmodule
bind sfs_status_regs sfs_status_regs_chk #(.BUSY_TIME(BUSY_TIME)) u_chk (.clk_sys, .sys_rst,
    .busy, .write_enable_latch, .quad_enable, .hold_enable, .current_addr_mode,
    .protect_scheme_select, .array_op_go, .array_op_refused);
`default_nettype wire

// ### dv/sfs_spi_host.sv
// Serial host model issuing status and array frames
`timescale 1ns/1ps
`default_nettype none
module sfs_spi_host (
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_mosi,
    input wire logic spi_miso_o,
    input wire logic spi_miso_oe
);
    logic [7:0] rd = 8'h00;
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end
    // Mode 0, MSB first; clock stands still between frames
    task automatic xfer(input logic [39:0] d, input int n);
        // Start off the system clock edge
        #3;
        spi_cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            spi_mosi = d[39-i];
            #7.5 spi_sclk = 1'b1;
            if (i >= 8) rd = {rd[6:0], spi_miso_o};
            #7.5 spi_sclk = 1'b0;
        end
        #7.5 spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi;
    endtask
endmodule
`default_nettype wire

// ### dv/tb.sv
// Self-checking bench for the status register block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic wp_n = 1'b1;
    logic spi_sclk, spi_cs_n, spi_mosi, spi_miso_o, spi_miso_oe, busy, write_enable_latch;
    logic suspend_flag, quad_enable, hold_enable, current_addr_mode, protect_scheme_select;
    logic drive_strength_hi, drive_strength_lo, array_op_go, array_op_refused;
    logic saw_go = 1'b0;
    logic saw_ref = 1'b0;
    logic [7:0] array_op_code;
    logic [31:0] array_op_addr;
    int fails = 0;
    int compares = 0;
    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (array_op_go) saw_go <= 1'b1;
        if (array_op_refused) saw_ref <= 1'b1;
    end
    sfs_spi_host u_host (.spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso_o, .spi_miso_oe);
    sfs_status_regs #(.BUSY_TIME(16'h0040)) u_dut (.clk_sys, .sys_rst, .clk_en, .spi_sclk,
        .spi_cs_n, .spi_mosi, .spi_miso_o, .spi_miso_oe, .wp_n, .busy, .write_enable_latch,
        .suspend_flag, .quad_enable, .hold_enable, .current_addr_mode, .protect_scheme_select,
        .drive_strength_hi, .drive_strength_lo, .array_op_go, .array_op_code, .array_op_addr,
        .array_op_refused);
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // Frame then the idle gap the front end needs
    task automatic cmd(input logic [7:0] op, input logic [31:0] rest, input int n);
        saw_go <= 1'b0;
        saw_ref <= 1'b0;
        u_host.xfer({op, rest}, n);
        repeat (10) @(posedge clk_sys);
    endtask
    task automatic idle;
        for (int i = 0; i < 300 && busy !== 1'b0; i++) @(posedge clk_sys);
        chk("busy end", busy, 0);
    endtask
    task automatic wsr(input logic [7:0] op, input logic [7:0] d);
        cmd(sfs_pkg::OP_WREN, 32'h0, 8);
        cmd(op, {d, 24'h0}, 16);
        idle();
    endtask
    task automatic rsr(input logic [7:0] op, input logic [7:0] exp);
        cmd(op, 32'h0, 16);
        chk("status byte", u_host.rd, exp);
    endtask
    task automatic do_reset;
        @(posedge clk_sys) sys_rst <= 1'b1;
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask
    task automatic t_basic;
        rsr(sfs_pkg::OP_RD_S1, 8'h00);
        rsr(sfs_pkg::OP_RD_S3, 8'h00);
        cmd(sfs_pkg::OP_WREN, 32'h0, 8);
        chk("wel", write_enable_latch, 1);
        cmd(sfs_pkg::OP_WRDI, 32'h0, 8);
        chk("wel", write_enable_latch, 0);
        cmd(sfs_pkg::OP_WR_S1, 32'h08000000, 16);
        rsr(sfs_pkg::OP_RD_S1, 8'h00);
        cmd(sfs_pkg::OP_WREN, 32'h0, 8);
        cmd(sfs_pkg::OP_WR_S1, 32'h48000000, 16);
        chk("busy", busy, 1);
        rsr(sfs_pkg::OP_RD_S1, 8'h49);
        cmd(sfs_pkg::OP_WREN, 32'h0, 8);
        chk("wel", write_enable_latch, 0);
        idle();
        rsr(sfs_pkg::OP_RD_S1, 8'h48);
    endtask
    task automatic t_wp;
        wsr(sfs_pkg::OP_WR_S1, 8'h80);
        @(posedge clk_sys) wp_n <= 1'b0;
        wsr(sfs_pkg::OP_WR_S1, 8'h00);
        // Refused write leaves the latch set
        rsr(sfs_pkg::OP_RD_S1, 8'h82);
        @(posedge clk_sys) wp_n <= 1'b1;
        wsr(sfs_pkg::OP_WR_S1, 8'h04);
        rsr(sfs_pkg::OP_RD_S1, 8'h04);
    endtask
    task automatic t_array;
        cmd(sfs_pkg::OP_ENTER_4B, 32'h0, 8);
        chk("addr mode", current_addr_mode, 1);
        cmd(sfs_pkg::OP_WREN, 32'h0, 8);
        cmd(sfs_pkg::OP_PAGE_PROG, 32'h03ff0000, 40);
        chk("refused", {saw_ref, saw_go, write_enable_latch}, 3'h4);
        cmd(sfs_pkg::OP_WREN, 32'h0, 8);
        cmd(sfs_pkg::OP_PAGE_PROG, 32'h00010000, 40);
        chk("taken", {saw_go, array_op_code}, {1'b1, 8'h02});
        chk("op addr", array_op_addr, 32'h00010000);
        cmd(sfs_pkg::OP_SUSPEND, 32'h0, 8);
        chk("suspend", suspend_flag, 1);
        cmd(sfs_pkg::OP_RESUME, 32'h0, 8);
        chk("suspend", suspend_flag, 0);
        idle();
        wsr(sfs_pkg::OP_WR_S2, 8'h40);
        cmd(sfs_pkg::OP_WREN, 32'h0, 8);
        cmd(sfs_pkg::OP_SECT_ERASE, 32'h00000000, 40);
        chk("refused", saw_ref, 1);
        cmd(sfs_pkg::OP_EXIT_4B, 32'h0, 8);
        chk("addr mode", current_addr_mode, 0);
    endtask
    task automatic t_cfg;
        for (int k = 0; k < 4; k++) begin
            wsr(sfs_pkg::OP_WR_S3, 8'(k << 5) | 8'h98);
            chk("drive", {drive_strength_hi, drive_strength_lo}, k);
        end
        rsr(sfs_pkg::OP_RD_S3, 8'h60);
        wsr(sfs_pkg::OP_WR_S3, 8'h06);
        chk("scheme", protect_scheme_select, 1);
        cmd(sfs_pkg::OP_WREN, 32'h0, 8);
        cmd(sfs_pkg::OP_PAGE_PROG, 32'h00800000, 32);
        chk("refused", saw_ref, 1);
        wsr(sfs_pkg::OP_WR_S2, 8'h06);
        wsr(sfs_pkg::OP_WR_S2, 8'h02);
        rsr(sfs_pkg::OP_RD_S2, 8'h06);
        chk("hold", {quad_enable, hold_enable}, 2'h2);
        wsr(sfs_pkg::OP_WR_S1, 8'h80);
        @(posedge clk_sys) wp_n <= 1'b0;
        wsr(sfs_pkg::OP_WR_S1, 8'h84);
        rsr(sfs_pkg::OP_RD_S1, 8'h84);
        @(posedge clk_sys) wp_n <= 1'b1;
        wsr(sfs_pkg::OP_WR_S2, 8'h07);
        wsr(sfs_pkg::OP_WR_S2, 8'h06);
        rsr(sfs_pkg::OP_RD_S2, 8'h07);
        do_reset();
        chk("addr mode", current_addr_mode, 1);
        cmd(sfs_pkg::OP_RD_S2, 32'h0, 16);
        chk("lockdown", u_host.rd[0], 0);
    endtask
    task automatic print_verdict;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        do_reset();
        t_basic();
        t_wp();
        t_array();
        t_cfg();
        print_verdict();
    end
    initial begin
        #1000000;
        fails++;
        print_verdict();
    end
endmodule
`default_nettype wire
